// File: src/tpg_consts.svh
// constants of the three-phase gate control block
`ifndef TPG_CONSTS_SVH
`define TPG_CONSTS_SVH

`define TPG_CLK_MHZ 10
`define TPG_STEP_NS 50
`define TPG_STEP_CYC ((`TPG_STEP_NS * `TPG_CLK_MHZ + 999) / 1000)
`define TPG_DT_MAX_NS 12000
`define TPG_DT_MAX_STEPS (`TPG_DT_MAX_NS / `TPG_STEP_NS)
`define TPG_BLANK_NS 500
`define TPG_BLANK_CYC ((`TPG_BLANK_NS * `TPG_CLK_MHZ + 999) / 1000)

`define TPG_A_DEADTIME 8'h00
`define TPG_A_CAL 8'h04
`define TPG_A_MODE 8'h08
`define TPG_A_SIMUL 8'h0c
`define TPG_A_STATUS 8'h10
`define TPG_A_INT_CLR 8'h14
`define TPG_A_INT_EN 8'h18
`define TPG_A_RPT_EN 8'h1c
`define TPG_A_STATE 8'h20

`define TPG_DT_RESET 8'h14
`define TPG_CAL_RESET 8'(`TPG_STEP_CYC)
`define TPG_RPT_RESET 5'h1f
`define TPG_INT_EN_RESET 5'h00
`define TPG_MODE_RESET 4'h2

`define TPG_M_CC 0
`define TPG_M_DESAT 1
`define TPG_M_ZDT 2
`define TPG_M_LOCK 3

`define TPG_F_OC 0
`define TPG_F_DESAT 1
`define TPG_F_PHASE 2
`define TPG_F_UV 3
`define TPG_F_REFUSE 4

`define TPG_IN_HI 0
`define TPG_IN_LO 3
`define TPG_IN_EN 6
`define TPG_IN_FLT 7

`define TPG_SIMUL_KEY 8'ha5
`define TPG_KEY_LSB 8
`define TPG_HSIZE_WORD 3'h2

`endif

// File: src/tpg_pkg.sv
// types of the three-phase gate control block
package tpg_pkg;

  typedef enum logic [1:0] {
    TPG_WANT_NONE,
    TPG_WANT_UP,
    TPG_WANT_LOW
  } tpg_want_t;

  typedef enum logic [1:0] {
    TPG_BUS_IDLE,
    TPG_BUS_WRITE,
    TPG_BUS_READ1,
    TPG_BUS_READ2
  } tpg_bus_t;

  typedef struct packed {
    logic hi_prev;
    logic lo_prev;
    logic hi_g;
    logic lo_g;
    logic boot_ok;
    logic refused;
    tpg_want_t want;
    logic [7:0] timer;
    logic [3:0] blank_cnt;
  } tpg_phase_t;

  typedef struct packed {
    logic [10:0] s1;
    logic [10:0] s2;
    logic [10:0] s3;
    logic [10:0] filt;
    tpg_bus_t bus;
    logic wr_ok;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic [7:0] dt;
    logic [7:0] cal;
    logic [3:0] mode;
    logic simul;
    logic simul_done;
    logic [4:0] status;
    logic [4:0] int_en;
    logic [4:0] rpt_en;
    logic [7:0] div;
    logic step;
  } tpg_top_t;

endpackage

// File: src/tpg_phase.sv
// one phase: gate sequencing, dead timer, bootstrap gate and blanking
`timescale 1ns/1ps
`include "tpg_consts.svh"

module tpg_phase
  import tpg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic step,
  input wire logic [7:0] dt_steps,
  input wire logic simul,
  input wire logic run,
  input wire logic hi_req,
  input wire logic lo_req,
  output logic hi_gate,
  output logic lo_gate,
  output logic blank,
  output logic boot_ok,
  output logic dt_busy,
  output logic refused
);

  tpg_phase_t q;
  tpg_phase_t next_q;
  logic hi_rise;
  logic lo_rise;
  logic chg;
  logic kill_hi;
  logic kill_lo;

  assign hi_rise = hi_req && !q.hi_prev;
  assign lo_rise = lo_req && !q.lo_prev;
  assign chg = (hi_req != q.hi_prev) || (lo_req != q.lo_prev);

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_q = q;
    kill_hi = 1'b0;
    kill_lo = 1'b0;
    next_q.hi_prev = hi_req;
    next_q.lo_prev = lo_req;
    next_q.refused = run && hi_rise && !q.boot_ok;
    if (chg) begin
      next_q.blank_cnt = 4'(`TPG_BLANK_CYC);
    end else if (q.blank_cnt != 4'h0) begin
      next_q.blank_cnt = q.blank_cnt - 4'h1;
    end
    if (!run) begin
      next_q.hi_g = 1'b0;
      next_q.lo_g = 1'b0;
      next_q.boot_ok = 1'b0;
      next_q.want = TPG_WANT_NONE;
      next_q.timer = 8'h00;
    end else if (simul) begin
      next_q.lo_g = lo_req;
      next_q.hi_g = hi_req && q.boot_ok;
      next_q.timer = 8'h00;
      if (lo_req) begin
        next_q.boot_ok = 1'b1;
      end
    end else begin
      if (lo_rise) begin
        next_q.want = TPG_WANT_LOW;
      end else if (hi_rise) begin
        next_q.want = TPG_WANT_UP;
      end
      kill_hi = q.hi_g && (!hi_req || next_q.want == TPG_WANT_LOW);
      kill_lo = q.lo_g && (!lo_req || next_q.want == TPG_WANT_UP);
      if (kill_hi || kill_lo) begin
        next_q.timer = dt_steps;
      end else if (step && q.timer != 8'h00) begin
        next_q.timer = q.timer - 8'h01;
      end
      if (kill_hi) begin
        next_q.hi_g = 1'b0;
      end
      if (kill_lo) begin
        next_q.lo_g = 1'b0;
      end
      if (!kill_hi && !kill_lo && q.timer == 8'h00) begin
        if (next_q.want == TPG_WANT_UP && hi_req && !q.lo_g && q.boot_ok) begin
          next_q.hi_g = 1'b1;
        end
        if (next_q.want == TPG_WANT_LOW && lo_req && !q.hi_g) begin
          next_q.lo_g = 1'b1;
          next_q.boot_ok = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign hi_gate = q.hi_g;
  assign lo_gate = q.lo_g;
  assign blank = (q.blank_cnt != 4'h0) && !simul;
  assign boot_ok = q.boot_ok;
  assign dt_busy = q.timer != 8'h00;
  assign refused = q.refused;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_lo_off;
    run && !simul && kill_lo && dt_steps != 8'h00;
  endsequence

  a_no_overlap: assert property (!simul |-> !(q.hi_g && q.lo_g))
    else $error("both gates of a phase on");
  a_boot_first: assert property ($rose(q.hi_g) |-> q.boot_ok)
    else $error("high side on before bootstrap charge");
  a_dt_hold: assert property (s_lo_off |=> !q.hi_g ##1 !q.hi_g)
    else $error("high side on inside dead time");
  a_blank_start: assert property (chg |=> q.blank_cnt != 4'h0)
    else $error("blanking not started on input change");

endmodule

// File: src/tpg_top.sv
// three-phase gate dead-time control with ahb-lite register slave
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - dead time in steps of calibrated cycles (100 ns at reset), 0 to 240 steps
// - host calibrates step length, device applies it
// - simultaneous conduction disables current-limit blanking
// - simultaneous setting accepted once per reset
// - operating modes settable, then frozen by lock
// - per-fault report and interrupt enables
// - status registers readable over the bus
// - input edge kills complement, selected after dead time
// - turn-off outside simultaneous mode and shutdown starts the phase dead timer
// - late complementary turn-on acts without delay
// - high side waits for first low side on
// - blank low-side current limit after input change
// - upper inputs active low, idle when undriven
// - reset holds all six gates off
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`include "tpg_consts.svh"

module tpg_top
  import tpg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [2:0] phase_upper_input_n,
  input wire logic [2:0] phase_lower_input,
  input wire logic enable_in,
  input wire logic [3:0] fault_in,
  output logic [2:0] upper_gate,
  output logic [2:0] lower_gate,
  output logic [2:0] ilimit_blank,
  output logic trickle_pump_en,
  output logic irq
);

  tpg_top_t q;
  tpg_top_t next_q;
  logic [10:0] raw;
  logic [10:0] agree;
  logic sel;
  logic run;
  logic [7:0] dt_eff;
  logic [4:0] clr;
  logic [4:0] events;
  logic [31:0] rd;
  logic [2:0] hi_g;
  logic [2:0] lo_g;
  logic [2:0] blank;
  logic [2:0] boot_ok;
  logic [2:0] dt_busy;
  logic [2:0] refused;

  //////////////////////////////////////////////////////////////////////////
  // pin inputs, upper ones inverted to active high
  assign raw = {fault_in, enable_in, phase_lower_input,
                ~phase_upper_input_n};
  assign agree = ~(q.s2 ^ q.s3);

  assign sel = hsel && htrans[1] && hready;

  // desaturation shutdown only when that behaviour is selected
  assign run = q.filt[`TPG_IN_EN] &&
               !(q.status[`TPG_F_DESAT] && q.mode[`TPG_M_DESAT]);

  assign dt_eff = q.mode[`TPG_M_ZDT] ? 8'h00 : q.dt;

  assign events = {|refused, q.filt[`TPG_IN_FLT +: 4]};

  //////////////////////////////////////////////////////////////////////////
  // read multiplexer
  always_comb begin
    rd = 32'h0000_0000;
    case (q.addr)
      `TPG_A_DEADTIME: begin
        rd[7:0] = q.dt;
      end
      `TPG_A_CAL: begin
        rd[7:0] = q.cal;
      end
      `TPG_A_MODE: begin
        rd[3:0] = q.mode;
      end
      `TPG_A_SIMUL: begin
        rd[1:0] = {q.simul_done, q.simul};
      end
      `TPG_A_STATUS: begin
        rd[4:0] = q.status;
      end
      `TPG_A_INT_EN: begin
        rd[4:0] = q.int_en;
      end
      `TPG_A_RPT_EN: begin
        rd[4:0] = q.rpt_en;
      end
      `TPG_A_STATE: begin
        rd[16:0] = {run, q.filt[`TPG_IN_EN], boot_ok, dt_busy,
                    lo_g, hi_g, blank};
      end
      default: begin
        rd = 32'h0000_0000;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_q = q;
    clr = 5'h00;

    // three-stage synchronisers with agreement filter
    next_q.s1 = raw;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    next_q.filt = (agree & q.s3) | (~agree & q.filt);

    // step time base from the calibrated divider
    if (q.div >= q.cal - 8'h01) begin
      next_q.div = 8'h00;
      next_q.step = 1'b1;
    end else begin
      next_q.div = q.div + 8'h01;
      next_q.step = 1'b0;
    end

    // data phase of the previous transfer
    unique case (q.bus)
      TPG_BUS_WRITE: begin
        if (q.wr_ok) begin
          case (q.addr)
            `TPG_A_DEADTIME: begin
              if (hwdata[7:0] > 8'(`TPG_DT_MAX_STEPS)) begin
                next_q.dt = 8'(`TPG_DT_MAX_STEPS);
              end else begin
                next_q.dt = hwdata[7:0];
              end
            end
            `TPG_A_CAL: begin
              if (hwdata[7:0] == 8'h00) begin
                next_q.cal = 8'h01;
              end else begin
                next_q.cal = hwdata[7:0];
              end
            end
            `TPG_A_MODE: begin
              if (!q.mode[`TPG_M_LOCK]) begin
                next_q.mode = hwdata[3:0];
              end
            end
            `TPG_A_SIMUL: begin
              if (!q.simul_done &&
                  hwdata[`TPG_KEY_LSB +: 8] == `TPG_SIMUL_KEY) begin
                next_q.simul = hwdata[0];
                next_q.simul_done = 1'b1;
              end
            end
            `TPG_A_INT_CLR: begin
              clr = hwdata[4:0];
            end
            `TPG_A_INT_EN: begin
              next_q.int_en = hwdata[4:0];
            end
            `TPG_A_RPT_EN: begin
              next_q.rpt_en = hwdata[4:0];
            end
            default: begin
              next_q.wr_ok = 1'b0;
            end
          endcase
        end
      end
      TPG_BUS_READ1: begin
        next_q.rdata = rd;
        next_q.bus = TPG_BUS_READ2;
      end
      TPG_BUS_IDLE, TPG_BUS_READ2: begin
        next_q.wr_ok = 1'b0;
      end
    endcase

    // address phase, never taken while the read wait state runs
    if (q.bus != TPG_BUS_READ1) begin
      if (sel) begin
        next_q.addr = haddr[7:0];
        next_q.wr_ok = hwrite && hsize == `TPG_HSIZE_WORD &&
                       haddr[31:8] == 24'h00_0000;
        next_q.bus = hwrite ? TPG_BUS_WRITE : TPG_BUS_READ1;
      end else begin
        next_q.bus = TPG_BUS_IDLE;
      end
    end

    // sticky status, a new event wins over a clear
    next_q.status = (q.status & ~clr) | (events & q.rpt_en);
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.bus <= TPG_BUS_IDLE;
      q.dt <= `TPG_DT_RESET;
      q.cal <= `TPG_CAL_RESET;
      q.mode <= `TPG_MODE_RESET;
      q.simul <= 1'b0;
      q.simul_done <= 1'b0;
      q.rpt_en <= `TPG_RPT_RESET;
      q.int_en <= `TPG_INT_EN_RESET;
    end else begin
      q <= next_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // one independent sequencer per phase
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : phase
      tpg_phase u_phase (
        .hclk(hclk),
        .hresetn(hresetn),
        .step(q.step),
        .dt_steps(dt_eff),
        .simul(q.simul),
        .run(run),
        .hi_req(q.filt[`TPG_IN_HI + g]),
        .lo_req(q.filt[`TPG_IN_LO + g]),
        .hi_gate(hi_g[g]),
        .lo_gate(lo_g[g]),
        .blank(blank[g]),
        .boot_ok(boot_ok[g]),
        .dt_busy(dt_busy[g]),
        .refused(refused[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  assign hreadyout = q.bus != TPG_BUS_READ1;
  assign hrdata = q.rdata;
  assign hresp = 1'b0;
  assign upper_gate = hi_g;
  assign lower_gate = lo_g;
  assign ilimit_blank = blank;
  assign trickle_pump_en = q.mode[`TPG_M_CC];
  assign irq = |(q.status & q.int_en);

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_addr;
    sel && !hwrite && q.bus != TPG_BUS_READ1;
  endsequence

  sequence s_rd_data;
    !hreadyout ##1 hreadyout;
  endsequence

  a_read_wait: assert property (s_rd_addr |=> s_rd_data)
    else $error("read data phase not one wait state");
  a_lock_hold: assert property (q.mode[`TPG_M_LOCK] |=> $stable(q.mode))
    else $error("locked mode changed");
  a_simul_once: assert property (q.simul_done |=> $stable(q.simul))
    else $error("simultaneous setting changed twice");
  a_simul_blank: assert property (q.simul |-> ilimit_blank == 3'h0)
    else $error("blanking active in simultaneous mode");
  a_dt_range: assert property (q.dt <= 8'(`TPG_DT_MAX_STEPS))
    else $error("dead time above range");
  a_rpt_mask: assert property (
    !q.rpt_en[`TPG_F_OC] && !q.status[`TPG_F_OC] |=> !q.status[`TPG_F_OC]
  ) else $error("unreported fault set status");

  //////////////////////////////////////////////////////////////////////////
  // register writes as seen at the end of their data phase
  sequence s_wr_to(logic [7:0] a);
    q.bus == TPG_BUS_WRITE && q.wr_ok && q.addr == a;
  endsequence

  a_write_fast: assert property (sel && hwrite |=> hreadyout)
    else $error("write data phase stalled");

  a_read_data: assert property (
    q.bus == TPG_BUS_READ1 |=> hrdata == $past(rd)
  ) else $error("read data not captured");

  a_cal_valid: assert property (q.cal != 8'h00)
    else $error("step length of zero cycles");

  a_step_each: assert property (q.cal == 8'h01 |=> q.step)
    else $error("step pulse missing at one cycle per step");

  a_dt_clamp: assert property (
    s_wr_to(`TPG_A_DEADTIME) ##0 hwdata[7:0] > 8'(`TPG_DT_MAX_STEPS)
    |=> q.dt == 8'(`TPG_DT_MAX_STEPS)
  ) else $error("dead time write not clamped");

  a_mode_take: assert property (
    s_wr_to(`TPG_A_MODE) ##0 !q.mode[`TPG_M_LOCK]
    |=> q.mode == $past(hwdata[3:0])
  ) else $error("unlocked mode write lost");

  a_simul_key: assert property (
    s_wr_to(`TPG_A_SIMUL) ##0 hwdata[`TPG_KEY_LSB +: 8] != `TPG_SIMUL_KEY
    |=> $stable(q.simul) && $stable(q.simul_done)
  ) else $error("simultaneous setting taken without key");

  a_simul_take: assert property (
    s_wr_to(`TPG_A_SIMUL) ##0 !q.simul_done &&
    hwdata[`TPG_KEY_LSB +: 8] == `TPG_SIMUL_KEY
    |=> q.simul == $past(hwdata[0]) && q.simul_done
  ) else $error("keyed simultaneous setting not taken");

  //////////////////////////////////////////////////////////////////////////
  // gate shutdown and fault status
  a_desat_stop: assert property (
    q.mode[`TPG_M_DESAT] && q.status[`TPG_F_DESAT]
    |=> upper_gate == 3'h0 && lower_gate == 3'h0
  ) else $error("gates on after desaturation stop");

  a_enable_off: assert property (
    !q.filt[`TPG_IN_EN] |=> boot_ok == 3'h0
  ) else $error("bootstrap flag kept outside enable state");

  a_event_sets: assert property (
    events[`TPG_F_OC] && q.rpt_en[`TPG_F_OC] |=> q.status[`TPG_F_OC]
  ) else $error("reported fault did not set status");

  a_refuse_flag: assert property (
    |refused && q.rpt_en[`TPG_F_REFUSE] |=> q.status[`TPG_F_REFUSE]
  ) else $error("refused high side not flagged");

  a_status_clear: assert property (
    s_wr_to(`TPG_A_INT_CLR) ##0 hwdata[`TPG_F_OC] && !events[`TPG_F_OC]
    |=> !q.status[`TPG_F_OC]
  ) else $error("status bit survived its clear");

endmodule

// File: verif/tpg_host_pins.sv
// host-side pin model: request levels onto the phase pins
`timescale 1ns/1ps
module tpg_host_pins (
  input wire logic drive,
  input wire logic [2:0] up_req,
  input wire logic [2:0] lo_req,
  output logic [2:0] phase_upper_input_n,
  output logic [2:0] phase_lower_input
);
  // released upper pins float to the pull-up, i.e. idle
  assign phase_upper_input_n = drive ? ~up_req : 3'h7;
  assign phase_lower_input = drive ? lo_req : 3'h0;
endmodule

// File: verif/three_phase_gate_deadtime_control_bench.sv
// self-checking bench of the three-phase gate control block
`timescale 1ns/1ps
`include "tpg_consts.svh"
module three_phase_gate_deadtime_control_bench;
  localparam int DT = 8;
  logic hclk, hresetn, hsel, hwrite, enable_in, drive;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, up_req, lo_req;
  logic [3:0] fault_in;
  wire logic hreadyout, hresp, trickle_pump_en, irq;
  wire logic [31:0] hrdata;
  wire logic [2:0] upper_gate, lower_gate, ilimit_blank, pu_n, pl;
  int bad_count, comparisons, n;

  tpg_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .phase_upper_input_n(pu_n),
    .phase_lower_input(pl), .enable_in(enable_in), .fault_in(fault_in),
    .upper_gate(upper_gate), .lower_gate(lower_gate),
    .ilimit_blank(ilimit_blank), .trickle_pump_en(trickle_pump_en),
    .irq(irq));
  tpg_host_pins host (.drive(drive), .up_req(up_req), .lo_req(lo_req),
    .phase_upper_input_n(pu_n), .phase_lower_input(pl));

  initial begin
    hclk = 0;
    forever #50 hclk = ~hclk;
  end

  //////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wait_ready;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 20) begin
        bad_count++;
        tally_and_finish;
      end
      @(posedge hclk);
    end
  endtask

  task ahb_write(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= 1'b1;
    hsize <= `TPG_HSIZE_WORD;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready;
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= 1'b0;
    hsize <= `TPG_HSIZE_WORD;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'b00;
    wait_ready;
    rd = hrdata;
    check(rd, exp);
    check(32'(hresp), 32'h0);
  endtask

  function automatic logic probe(input int sel);
    case (sel)
      0: probe = upper_gate[0];
      1: probe = lower_gate[0];
      2: probe = ~lower_gate[0];
      default: probe = ilimit_blank[0];
    endcase
  endfunction

  // cycles until the probed signal is high, bounded
  task count_until(input int sel);
    n = 0;
    while (probe(sel) !== 1'b1) begin
      @(posedge hclk);
      n++;
      if (n > 60) begin
        bad_count++;
        tally_and_finish;
      end
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hsize = 3'h2; hwdata = 0; enable_in = 0; drive = 0;
    up_req = 0; lo_req = 0; fault_in = 0;
    bad_count = 0; comparisons = 0;
    repeat (20) @(posedge hclk);
    check(32'({upper_gate, lower_gate, irq}), 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(`TPG_A_DEADTIME, 32'(`TPG_DT_RESET));
    rdchk(`TPG_A_MODE, 32'(`TPG_MODE_RESET));
    rdchk(`TPG_A_SIMUL, 32'h0);
    rdchk(`TPG_A_RPT_EN, 32'(`TPG_RPT_RESET));
    rdchk(`TPG_A_INT_EN, 32'h0);
    rdchk(8'h40, 32'h0);
    ahb_write(`TPG_A_DEADTIME, 32'hff);
    rdchk(`TPG_A_DEADTIME, 32'(`TPG_DT_MAX_STEPS));
    ahb_write(`TPG_A_DEADTIME, DT);
    ahb_write(`TPG_A_CAL, 32'h2);
    rdchk(`TPG_A_CAL, 32'h2);
    ahb_write(`TPG_A_CAL, 32'h0);
    rdchk(`TPG_A_CAL, 32'h1);
    enable_in <= 1'b1;
    drive <= 1'b1;
    repeat (8) @(posedge hclk);
    // charge bootstrap of phase a first
    lo_req <= 3'h1;
    count_until(3);
    check(32'(n <= 6), 32'h1);
    count_until(1);
    up_req <= 3'h1;
    count_until(2);
    count_until(0);
    check(32'(n >= DT && n <= DT + 3), 32'h1);
    // zero dead time: lower side follows the kill at once
    ahb_write(`TPG_A_MODE, 32'h6);
    lo_req <= 3'h0;
    repeat (6) @(posedge hclk);
    lo_req <= 3'h1;
    count_until(1);
    check(32'(n <= 7), 32'h1);
    ahb_write(`TPG_A_MODE, 32'(`TPG_MODE_RESET));
    up_req <= 3'h0;
    lo_req <= 3'h0;
    repeat (40) @(posedge hclk);
    lo_req <= 3'h1;
    count_until(1);
    check(32'(n <= 6), 32'h1);
    // desaturation stop with shutdown selected
    fault_in <= 4'h2;
    repeat (8) @(posedge hclk);
    check(32'(lower_gate[0]), 32'h0);
    rdchk(`TPG_A_STATE, 32'h8000);
    fault_in <= 4'h0;
    repeat (8) @(posedge hclk);
    lo_req <= 3'h0;
    ahb_write(`TPG_A_INT_CLR, 32'h1f);
    up_req <= 3'h2;
    repeat (20) @(posedge hclk);
    check(32'(upper_gate[1]), 32'h0);
    up_req <= 3'h0;
    rdchk(`TPG_A_STATUS, 32'h10);
    ahb_write(`TPG_A_INT_EN, 32'h10);
    @(posedge hclk);
    check(32'(irq), 32'h1);
    ahb_write(`TPG_A_INT_EN, 32'h0);
    @(posedge hclk);
    check(32'(irq), 32'h0);
    ahb_write(`TPG_A_INT_CLR, 32'h1f);
    ahb_write(`TPG_A_RPT_EN, 32'h1e);
    fault_in <= 4'h1;
    repeat (8) @(posedge hclk);
    rdchk(`TPG_A_STATUS, 32'h0);
    ahb_write(`TPG_A_RPT_EN, 32'h1f);
    repeat (8) @(posedge hclk);
    rdchk(`TPG_A_STATUS, 32'h1);
    ahb_write(`TPG_A_INT_EN, 32'h1);
    @(posedge hclk);
    check(32'(irq), 32'h1);
    fault_in <= 4'h0;
    repeat (8) @(posedge hclk);
    ahb_write(`TPG_A_INT_CLR, 32'h1);
    @(posedge hclk);
    check(32'(irq), 32'h0);
    rdchk(`TPG_A_STATUS, 32'h0);
    ahb_write(`TPG_A_MODE, 32'h9);
    rdchk(`TPG_A_MODE, 32'h9);
    check(32'(trickle_pump_en), 32'h1);
    ahb_write(`TPG_A_MODE, 32'h2);
    rdchk(`TPG_A_MODE, 32'h9);
    ahb_write(`TPG_A_SIMUL, 32'h1);
    rdchk(`TPG_A_SIMUL, 32'h0);
    ahb_write(`TPG_A_SIMUL, 32'ha501);
    rdchk(`TPG_A_SIMUL, 32'h3);
    ahb_write(`TPG_A_SIMUL, 32'ha500);
    rdchk(`TPG_A_SIMUL, 32'h3);
    // simultaneous mode: no blanking on a change
    lo_req <= 3'h4;
    n = 0;
    repeat (12) begin
      @(posedge hclk);
      if (ilimit_blank[2] !== 1'b0) n++;
    end
    check(32'(n), 32'h0);
    check(32'(lower_gate[2]), 32'h1);
    hresetn <= 1'b0;
    @(negedge hclk);
    check(32'({upper_gate, lower_gate, ilimit_blank}), 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(`TPG_A_MODE, 32'(`TPG_MODE_RESET));
    rdchk(`TPG_A_SIMUL, 32'h0);
    tally_and_finish;
  end
endmodule
